// File: src/manual_output_regs.svh
// register offsets, feedback and control bit positions, register reset values
// assumes inclusion by bare name from the design files
`ifndef MANUAL_OUTPUT_REGS_SVH
`define MANUAL_OUTPUT_REGS_SVH

`define CH0_FEEDBACK_OFS 4'h0
`define CH0_CONTROL_OFS 4'h2
`define CH1_FEEDBACK_OFS 4'h4
`define CH1_CONTROL_OFS 4'h6
`define DIAG_CONFIG_OFS 4'h8
`define DIAG_STATUS_OFS 4'h9

`define CTL_RUN_PERMIT_BIT 0
`define CTL_DIRECT_SEL_BIT 1
`define CTL_FORCE_LEVEL_BIT 2

`define FB_RUN_ACTIVE_BIT 0
`define FB_OUTPUT_ECHO_BIT 1
`define FB_INPUT_ECHO_BIT 2
`define FB_PULSE_FAULT_BIT 4
`define FB_PARAM_REJECT_BIT 5
`define FB_OUTPUT_SHORT_BIT 6
`define FB_SUPPLY_SHORT_BIT 7

`define CFG_GROUP_DIAG_BIT 0
`define CFG_OUT_DIAG0_BIT 1
`define CFG_OUT_DIAG1_BIT 2

`define CONTROL_RESET 8'h00
`define CONFIG_RESET 8'h00
`define BYTE_ZERO 8'h00

`endif

// File: src/manual_output_pkg.sv
// types shared by the channel and the top module
// assumes the regs header is compiled alongside
package manual_output_pkg;

	typedef struct packed {
		logic force_level;
		logic direct_sel;
		logic run_permit;
	} chan_ctl_t;

	typedef struct packed {
		logic supply_short;
		logic output_short;
		logic param_reject;
		logic pulse_fault;
		logic reserved;
		logic input_echo;
		logic output_echo;
		logic run_active;
	} chan_fb_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SEQ = 3'b010,
		ST_DIRECT = 3'b100
	} chan_state_t;

endpackage : manual_output_pkg

// File: src/input_sync3.sv
// three-stage synchroniser; output changes once stages two and three agree
// assumes an asynchronous input level
`timescale 1ns/1ps
module input_sync3 (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic async_in,
	output logic sync_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	always_ff @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			sync_out <= 1'b0;
		end
		else
		begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				sync_out <= s3_r;
		end
	end
endmodule : input_sync3

// File: src/output_channel.sv
// one channel: sequence handover, direct output control, fault flags
// assumes synchronised pin levels and a one-cycle control write strobe
`timescale 1ns/1ps
module output_channel (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input manual_output_pkg::chan_ctl_t ctl_in,
	input wire logic seq_level_in,
	input wire logic seq_done_in,
	input wire logic pulse_fault_in,
	input wire logic short_in,
	input wire logic short_diag_en_in,
	output logic out_level_out,
	output logic run_active_out,
	output logic pulse_fault_out,
	output logic short_out,
	output logic seq_abort_out
);
	import manual_output_pkg::*;

	chan_state_t state_r;
	chan_state_t state_nxt;
	logic enter_direct;
	logic leave_direct;

	// direct mode entered only with permit clear
	// entry condition
	assign enter_direct = ctl_in.direct_sel && !ctl_in.run_permit;
	assign leave_direct = (state_r == ST_DIRECT) && !ctl_in.direct_sel;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
			begin
				if (enter_direct)
					state_nxt = ST_DIRECT;
				else if (ctl_in.run_permit)
					state_nxt = ST_SEQ;
			end
			ST_SEQ:
			begin
				if (!ctl_in.run_permit || seq_done_in)
					state_nxt = ST_IDLE;
			end
			ST_DIRECT:
			begin
				if (!ctl_in.direct_sel)
					state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			state_r <= ST_IDLE;
			out_level_out <= 1'b0;
			run_active_out <= 1'b0;
			pulse_fault_out <= 1'b0;
			short_out <= 1'b0;
			seq_abort_out <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			seq_abort_out <= (state_r != ST_DIRECT) && (state_nxt == ST_DIRECT);
			run_active_out <= (state_nxt == ST_SEQ);
			// fault cleared on entry; latched while sequencing
			if ((state_r != ST_DIRECT) && (state_nxt == ST_DIRECT))
				pulse_fault_out <= 1'b0;
			else if (pulse_fault_in && (state_r == ST_SEQ))
				pulse_fault_out <= 1'b1;
			else if (state_nxt == ST_SEQ && state_r == ST_IDLE)
				pulse_fault_out <= 1'b0;
			short_out <= short_in && short_diag_en_in;
			if (state_nxt == ST_DIRECT)
				out_level_out <= ctl_in.force_level;
			else if (leave_direct || state_nxt == ST_IDLE)
				out_level_out <= 1'b0;
			else
				out_level_out <= seq_level_in;
		end
	end
endmodule : output_channel

// File: src/manual_output_override_diag.sv
// top: register port, two output channels, module-wide fault flags
// assumes a register master with one-cycle strobes and pins from outside the clock domain
//
// Overview of operation
// - direct control entered only with direct-select set and run permit clear
// - entering direct control clears run flag, pulse fault and aborts sequence
// - in direct control the output follows the forced-level bit
// - clearing direct-select leaves direct control and drives output low
// - control byte: bit0 permit, bit1 direct select, bit2 forced level
// - feedback byte: bit0 run flag, bit1 output level, bit2 gating input
// - invalid parameters set reject flag bit5, channels stay unparameterised
// - pulse timing faults reported per channel in feedback bit4
// - sensor supply short flagged at bit7 for both channels
// - output short flagged at bit6 only with output diagnostics on
// - diagnostic message raised only with group diagnostics enabled
`timescale 1ns/1ps
`include "manual_output_regs.svh"
module manual_output_override_diag #(
	parameter int CHANNELS = 2
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	output logic [7:0] reg_rdata_out,
	input wire logic param_load_in,
	input wire logic param_valid_in,
	input wire logic [1:0] gating_input_in,
	input wire logic [1:0] output_short_in,
	input wire logic supply_short_in,
	input wire logic [1:0] seq_level_in,
	input wire logic [1:0] seq_done_in,
	input wire logic [1:0] pulse_timing_fault_in,
	output logic [1:0] switched_output_out,
	output logic [1:0] seq_abort_out,
	output logic diag_message_out
);
	import manual_output_pkg::*;

	// ============================================================
	// register port
	chan_ctl_t ctl_r [CHANNELS];
	logic [7:0] config_r;
	logic param_reject_r;
	logic parameterised_r;
	logic [7:0] rdata_nxt;
	logic [1:0] gating_sync;
	logic [1:0] short_sync;
	logic supply_sync;
	logic [1:0] out_level;
	logic [1:0] run_active;
	logic [1:0] pulse_fault;
	logic [1:0] out_short;
	logic [1:0] abort;
	chan_fb_t fb [CHANNELS];
	logic wr_ctl0;
	logic wr_ctl1;
	logic wr_cfg;
	logic diag_nxt;
	logic [1:0] seq_done_gated;
	logic [1:0] seq_fault_gated;

	function automatic chan_ctl_t byte_to_ctl(input logic [7:0] b);
		chan_ctl_t c;
		c.run_permit = b[`CTL_RUN_PERMIT_BIT];
		c.direct_sel = b[`CTL_DIRECT_SEL_BIT];
		c.force_level = b[`CTL_FORCE_LEVEL_BIT];
		return c;
	endfunction : byte_to_ctl

	assign wr_ctl0 = reg_write_in && (reg_addr_in == `CH0_CONTROL_OFS);
	assign wr_ctl1 = reg_write_in && (reg_addr_in == `CH1_CONTROL_OFS);
	assign wr_cfg = reg_write_in && (reg_addr_in == `DIAG_CONFIG_OFS);

	always_ff @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			ctl_r[0] <= byte_to_ctl(`CONTROL_RESET);
			ctl_r[1] <= byte_to_ctl(`CONTROL_RESET);
			config_r <= `CONFIG_RESET;
		end
		else
		begin
			if (wr_ctl0)
				ctl_r[0] <= byte_to_ctl(reg_wdata_in);
			if (wr_ctl1)
				ctl_r[1] <= byte_to_ctl(reg_wdata_in);
			if (wr_cfg)
				config_r <= reg_wdata_in;
		end
	end

	// ============================================================
	// parameter acceptance
	always_ff @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			param_reject_r <= 1'b0;
			parameterised_r <= 1'b1;
		end
		else if (param_load_in)
		begin
			param_reject_r <= !param_valid_in;
			parameterised_r <= param_valid_in;
		end
	end

	// ============================================================
	// pin synchronisers
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_ch
			input_sync3 u_gate (
				.mclk_in(mclk_in),
				.reset_n_in(reset_n_in),
				.async_in(gating_input_in[g]),
				.sync_out(gating_sync[g])
			);
			input_sync3 u_short (
				.mclk_in(mclk_in),
				.reset_n_in(reset_n_in),
				.async_in(output_short_in[g]),
				.sync_out(short_sync[g])
			);
			// unparameterised channels run no sequence
			assign seq_done_gated[g] = seq_done_in[g] || !parameterised_r;
			assign seq_fault_gated[g] = pulse_timing_fault_in[g] && parameterised_r;
			output_channel u_chan (
				.mclk_in(mclk_in),
				.reset_n_in(reset_n_in),
				.ctl_in(ctl_r[g]),
				.seq_level_in(seq_level_in[g] && parameterised_r),
				.seq_done_in(seq_done_gated[g]),
				.pulse_fault_in(seq_fault_gated[g]),
				.short_in(short_sync[g]),
				.short_diag_en_in(config_r[`CFG_OUT_DIAG0_BIT + g]),
				.out_level_out(out_level[g]),
				.run_active_out(run_active[g]),
				.pulse_fault_out(pulse_fault[g]),
				.short_out(out_short[g]),
				.seq_abort_out(abort[g])
			);
			assign fb[g].run_active = run_active[g];
			assign fb[g].output_echo = out_level[g];
			assign fb[g].input_echo = gating_sync[g];
			assign fb[g].reserved = 1'b0;
			assign fb[g].pulse_fault = pulse_fault[g];
			assign fb[g].param_reject = param_reject_r;
			assign fb[g].output_short = out_short[g];
			assign fb[g].supply_short = supply_sync;
		end
	endgenerate

	input_sync3 u_supply (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.async_in(supply_short_in),
		.sync_out(supply_sync)
	);

	// ============================================================
	// read mux and outputs
	assign rdata_nxt = !reg_read_in ? `BYTE_ZERO :
		(reg_addr_in == `CH0_FEEDBACK_OFS) ? fb[0] :
		(reg_addr_in == `CH1_FEEDBACK_OFS) ? fb[1] :
		(reg_addr_in == `DIAG_CONFIG_OFS) ? config_r :
		(reg_addr_in == `DIAG_STATUS_OFS) ? {7'h00, diag_message_out} :
		`BYTE_ZERO;

	assign diag_nxt = config_r[`CFG_GROUP_DIAG_BIT] &&
		(param_reject_r || supply_sync || (|out_short));

	always_ff @(posedge mclk_in)
	begin
		if (!reset_n_in)
		begin
			reg_rdata_out <= `BYTE_ZERO;
			switched_output_out <= 2'b00;
			seq_abort_out <= 2'b00;
			diag_message_out <= 1'b0;
		end
		else
		begin
			reg_rdata_out <= rdata_nxt;
			switched_output_out <= out_level;
			seq_abort_out <= abort;
			diag_message_out <= diag_nxt;
		end
	end
endmodule : manual_output_override_diag

// File: test/manual_output_override_diag_assertions.sv
// checker: register port answers and switched output timing of the top module
// assumes binding onto manual_output_override_diag, one clock
`timescale 1ns/1ps
`include "manual_output_regs.svh"
module manual_output_checker (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [1:0] switched_output_out,
	input wire logic [1:0] seq_abort_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!reset_n_in);
	wire w0 = reg_write_in && reg_addr_in == `CH0_CONTROL_OFS;
	wire w1 = reg_write_in && reg_addr_in == `CH1_CONTROL_OFS;
	wire rc = reg_addr_in == `CH0_CONTROL_OFS || reg_addr_in == `CH1_CONTROL_OFS;
	// ==========
	// assertions
	a_rdata_one_cycle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 8'h00)
		else $error("read data outside its cycle");
	a_ctl_write_only: assert property (reg_read_in && rc |=> reg_rdata_out == 8'h00)
		else $error("control byte read back");
	a_unmapped_zero: assert property (reg_read_in && reg_addr_in > 4'h9 |=> !reg_rdata_out)
		else $error("unmapped read not zero");
	// entry from a running sequence passes idle first, so the pin may settle one cycle later
	a_force_ch0: assert property (w0 && reg_wdata_in[1:0] == 2'b10 ##1 !w0
		|=> ##2 switched_output_out[0] == $past(reg_wdata_in[2], 4))
		else $error("ch0 forced level");
	a_force_ch1: assert property (w1 && reg_wdata_in[1:0] == 2'b10 ##1 !w1
		|=> ##2 switched_output_out[1] == $past(reg_wdata_in[2], 4))
		else $error("ch1 forced level");
	a_leave_low: assert property (w0 && reg_wdata_in[1:0] == 2'b00 ##1 !w0
		|=> ##1 !switched_output_out[0]) else $error("output not low after leaving");
	a_abort_cause: assert property ($rose(seq_abort_out[0])
		|-> ($past(w0, 3) && $past(reg_wdata_in[1:0], 3) == 2'b10) ||
		($past(w0, 4) && $past(reg_wdata_in[1:0], 4) == 2'b10))
		else $error("stray abort");
	a_abort_single: assert property (seq_abort_out[1] |=> !seq_abort_out[1])
		else $error("abort longer than one cycle");
endmodule : manual_output_checker

bind manual_output_override_diag manual_output_checker chk (.mclk_in, .reset_n_in,
	.reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out,
	.switched_output_out, .seq_abort_out);

// File: test/controller_model.sv
// register master standing for the supervising controller
// assumes the block's clock and read data one cycle after the strobe
`timescale 1ns/1ps
module controller_model (
	input wire logic mclk_in,
	input wire logic [7:0] rdata_in,
	output logic [3:0] addr_out = 4'h0,
	output logic [7:0] wdata_out = 8'h00,
	output logic write_out = 1'b0,
	output logic read_out = 1'b0
);
	// ==========
	// bus cycles
	// whole control bytes
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr_out <= a;
		wdata_out <= d;
		write_out <= 1'b1;
		@(posedge mclk_in);
		write_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_in);
		addr_out <= a;
		read_out <= 1'b1;
		@(posedge mclk_in);
		read_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
	endtask : rd
endmodule : controller_model

// File: test/manual_output_override_diag_tb.sv
// bench: direct output control, feedback bytes and fault gating
// assumes the design files and the controller model are compiled first
`timescale 1ns/1ps
module manual_output_override_diag_tb;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr_s;
	logic rd_s;
	logic [7:0] rdata;
	logic load = 1'b0;
	logic valid = 1'b1;
	logic [1:0] gate = 2'b00;
	logic [1:0] oshort = 2'b00;
	logic sshort = 1'b0;
	logic [1:0] slevel = 2'b01;
	logic [1:0] pfault = 2'b00;
	logic [1:0] dout;
	logic [1:0] abort;
	logic diag;
	logic [7:0] fb;
	logic [31:0] seed = 32'h0000_0047;
	logic [3:0] regs [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h3, 4'h8, 4'hF};
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	always #5 mclk_in = ~mclk_in;
	manual_output_override_diag dut (.mclk_in, .reset_n_in, .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata),
		.param_load_in(load), .param_valid_in(valid), .gating_input_in(gate),
		.output_short_in(oshort), .supply_short_in(sshort), .seq_level_in(slevel),
		.seq_done_in(2'b00), .pulse_timing_fault_in(pfault), .switched_output_out(dout),
		.seq_abort_out(abort), .diag_message_out(diag));
	controller_model ctl (.mclk_in, .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.write_out(wr_s), .read_out(rd_s));
	// ==========
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs
	function automatic logic [7:0] fb_byte(input logic run, lv, din, pf, pr, os, ss);
		return {ss, os, pr, pf, 1'b0, din, lv, run};
	endfunction : fb_byte
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : idle
	task automatic fb_both(input logic pr, os0, ss);
		for (int c = 0; c < 2; c++)
		begin
			ctl.rd(c ? 4'h4 : 4'h0, fb);
			chk(fb, fb_byte(0, 0, gate[c], 0, pr, os0 && c == 0, ss));
		end
	endtask : fb_both
	task automatic print_verdict;
		if (error_cnt == 0 && comparisons > 0)
		begin
			$display("All tests passed");
		end
		else
		begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict
	always @(posedge mclk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			error_cnt++;
			print_verdict();
		end
	end
	// ==========
	// scenarios
	initial
	begin
		repeat (16) @(posedge mclk_in);
		reset_n_in <= 1'b1;
		ctl.wr(4'h0, 8'hFF);
		ctl.wr(4'hF, 8'hFF);
		foreach (regs[i])
		begin
			ctl.rd(regs[i], fb);
			chk(fb, 8'h00);
		end
		for (int i = 0; i < 4; i++)
		begin
			ctl.wr(i[0] ? 4'h6 : 4'h2, {5'h00, i[1], 2'b10});
			idle(2);
			chk(dout[i[0]], i[1]);
			ctl.rd(i[0] ? 4'h4 : 4'h0, fb);
			chk(fb, fb_byte(0, i[1], 0, 0, 0, 0, 0));
		end
		ctl.wr(4'h2, 8'h04);
		ctl.wr(4'h6, 8'h04);
		idle(2);
		chk(dout, 2'b00);
		ctl.wr(4'h2, 8'h03);
		idle(3);
		chk(dout, 2'b01);
		@(posedge mclk_in);
		pfault <= 2'b01;
		@(posedge mclk_in);
		pfault <= 2'b00;
		idle(2);
		ctl.rd(4'h0, fb);
		chk(fb, fb_byte(1, 1, 0, 1, 0, 0, 0));
		ctl.wr(4'h2, 8'h02);
		idle(3);
		chk(abort, 2'b01);
		idle(1);
		chk(abort, 2'b00);
		ctl.rd(4'h0, fb);
		chk(fb, 8'h00);
		ctl.wr(4'h2, 8'h00);
		for (int j = 0; j < 2; j++)
		begin
			seed = xs(seed);
			@(posedge mclk_in);
			gate <= seed[1:0];
			idle(6);
			fb_both(0, 0, 0);
		end
		@(posedge mclk_in);
		sshort <= 1'b1;
		oshort <= 2'b01;
		idle(6);
		fb_both(0, 0, 1);
		chk(diag, 0);
		ctl.wr(4'h8, 8'h03);
		idle(6);
		fb_both(0, 1, 1);
		chk(diag, 1);
		@(posedge mclk_in);
		sshort <= 1'b0;
		oshort <= 2'b00;
		idle(6);
		chk(diag, 0);
		@(posedge mclk_in);
		load <= 1'b1;
		valid <= 1'b0;
		@(posedge mclk_in);
		load <= 1'b0;
		valid <= 1'b1;
		idle(3);
		fb_both(1, 0, 0);
		chk(diag, 1);
		ctl.rd(4'h9, fb);
		chk(fb, 8'h01);
		ctl.wr(4'h2, 8'h03);
		idle(3);
		chk(dout, 2'b00);
		print_verdict();
	end
endmodule : manual_output_override_diag_tb
